/* File: rtl/pend_table.sv */
// Pending-interrupt memory: one bit per external IRQ, read out registered.
// Assumes a single clk_sys domain; set wins over clear at the same index.
`timescale 1ns/1ps
`default_nettype none
module pend_table (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  setEn,
    input  wire logic [5:0]            setIdx,
    input  wire logic                  clrEn,
    input  wire logic [5:0]            clrIdx,
    output logic [63:0]                pendBits_r
);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pendBits_r <= 64'h0;
        end else begin
            for (int i = 0; i < 64; i++) begin
                if (setEn && setIdx == 6'(i)) begin
                    pendBits_r[i] <= 1'b1;
                end else if (clrEn && clrIdx == 6'(i)) begin
                    pendBits_r[i] <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sys_control_regs.sv */
// System control register block behind an AXI4-Lite slave.
// Assumes privilege arrives as AxPROT[0]; core signals share clk_sys.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sys_control_regs
    import sysctl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [6:0]  activeExc,
    input  wire logic        preemptedActive,
    input  wire logic        nmiEntry,
    input  wire logic        dsTaken,
    input  wire logic        tickTaken,
    input  wire logic        irqTaken,
    input  wire logic [5:0]  irqTakenNum,
    output logic             noIfthenFold_r,
    output logic             noWriteBuffer_r,
    output logic             noMulticycleInt_r,
    output logic             nmiPending_r,
    output logic             dsPending_r,
    output logic             tickPending_r,
    output logic [63:0]      irqPending_r,
    output logic             irq_r
);
    // ==========================================================
    // Bus front end
    bus_state_t wrState_r;
    logic       awHeld_r;
    logic       wHeld_r;
    logic [11:0] awAddr_r;
    logic       awPriv_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic [2:0] evStat_r;
    logic [2:0] evMask_r;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake  = s_axi_wvalid && s_axi_wready;
    wire haveAw = awHeld_r || awTake;
    wire haveW  = wHeld_r || wTake;
    wire [11:0] wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
    wire        wPriv = awHeld_r ? awPriv_r : s_axi_awprot[0];
    wire [31:0] wDat  = wHeld_r ? wData_r : s_axi_wdata;
    wire [3:0]  wStb  = wHeld_r ? wStrb_r : s_axi_wstrb;
    wire doWrite = (wrState_r == BUS_IDLE) && haveAw && haveW;

    function automatic logic known(input logic [11:0] a);
        known = (a == OFF_AUX_CTRL) || (a == OFF_PROC_ID) || (a == OFF_INT_CTRL)
             || (a == OFF_SW_TRIG) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK)
             || (a == OFF_CORE_STAT);
    endfunction

    // Only full-word privileged writes to a mapped word take effect
    wire wOk = wPriv && (wStb == 4'hF) && known(wAddr);
    wire wr = doWrite && wOk;
    wire wrAux  = wr && wAddr == OFF_AUX_CTRL;
    wire wrIc   = wr && wAddr == OFF_INT_CTRL;
    wire wrTrig = wr && wAddr == OFF_SW_TRIG;
    wire wrStat = wr && wAddr == OFF_IRQ_STAT;
    wire wrMask = wr && wAddr == OFF_IRQ_MASK;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wrState_r <= BUS_IDLE;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 12'h000;
            awPriv_r <= 1'b0;
            wData_r <= RESET_WORD;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wrState_r)
                BUS_IDLE: begin
                    if (awTake) begin
                        awHeld_r <= 1'b1;
                        awAddr_r <= s_axi_awaddr;
                        awPriv_r <= s_axi_awprot[0];
                    end
                    if (wTake) begin
                        wHeld_r <= 1'b1;
                        wData_r <= s_axi_wdata;
                        wStrb_r <= s_axi_wstrb;
                    end
                    s_axi_awready <= !haveAw;
                    s_axi_wready <= !haveW;
                    if (doWrite) begin
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        awHeld_r <= 1'b0;
                        wHeld_r <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wOk ? RESP_OKAY : RESP_SLVERR;
                        wrState_r <= BUS_RESP;
                    end
                end
                BUS_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wrState_r <= BUS_IDLE;
                    end
                end
                default: wrState_r <= BUS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            noIfthenFold_r <= 1'b0;
            noWriteBuffer_r <= 1'b0;
            noMulticycleInt_r <= 1'b0;
        end else if (wrAux) begin
            noIfthenFold_r <= wDat[AUX_NO_FOLD];
            noWriteBuffer_r <= wDat[AUX_NO_WBUF];
            noMulticycleInt_r <= wDat[AUX_NO_MCYC];
        end
    end

    // Set wins over a simultaneous clear or handler entry
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            nmiPending_r <= 1'b0;
            dsPending_r <= 1'b0;
            tickPending_r <= 1'b0;
        end else begin
            if (wrIc && wDat[IC_NMI_SET]) begin
                nmiPending_r <= 1'b1;
            end else if (nmiEntry) begin
                nmiPending_r <= 1'b0;
            end
            if (wrIc && wDat[IC_DS_SET]) begin
                dsPending_r <= 1'b1;
            end else if ((wrIc && wDat[IC_DS_CLR]) || dsTaken) begin
                dsPending_r <= 1'b0;
            end
            if (wrIc && wDat[IC_TICK_SET]) begin
                tickPending_r <= 1'b1;
            end else if ((wrIc && wDat[IC_TICK_CLR]) || tickTaken) begin
                tickPending_r <= 1'b0;
            end
        end
    end

    pend_table u_pend (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .setEn      (wrTrig),
        .setIdx     (wDat[TRIG_W-1:0]),
        .clrEn      (irqTaken),
        .clrIdx     (irqTakenNum),
        .pendBits_r (irqPending_r)
    );

    // ==========================================================
    // Pending priority: NMI, then tick, deferred, lowest IRQ
    logic [6:0] lowIrq;
    always_comb begin
        lowIrq = EXC_NONE;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irqPending_r[i]) begin
                lowIrq = EXC_IRQ0 + 7'(i);
            end
        end
    end
    wire anyIrq = |irqPending_r;
    wire [6:0] pendNum = nmiPending_r ? EXC_NMI : tickPending_r ? EXC_TICK
                       : dsPending_r ? EXC_DS : lowIrq;
    wire [31:0] icWord = {nmiPending_r, 2'b00, dsPending_r, 1'b0, tickPending_r, 3'b000,
                          anyIrq, 3'b000, pendNum, !preemptedActive, 4'h0, activeExc};
    wire [31:0] idWord = {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT, ID_PART, ID_REVISION};

    // ==========================================================
    // Event status, mask and interrupt
    wire [2:0] evSet;
    assign evSet[EV_SW_TRIG] = wrTrig;
    assign evSet[EV_NMI]    = wrIc && wDat[IC_NMI_SET];
    assign evSet[EV_DENIED] = doWrite && !wOk;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            evStat_r <= 3'b000;
            evMask_r <= 3'b000;
            irq_r <= 1'b0;
        end else begin
            evStat_r <= evSet | (evStat_r & ~(wrStat ? wDat[2:0] : 3'b000));
            if (wrMask) begin
                evMask_r <= wDat[2:0];
            end
            irq_r <= |(evStat_r & evMask_r);
        end
    end

    // ==========================================================
    // Read channel: one cycle after address acceptance
    logic rBusy_r;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire rOk = s_axi_arprot[0] && known(s_axi_araddr);
    wire [31:0] rWord = (s_axi_araddr == OFF_AUX_CTRL)
                        ? {29'h0, noIfthenFold_r, noWriteBuffer_r, noMulticycleInt_r}
                      : (s_axi_araddr == OFF_PROC_ID)   ? idWord
                      : (s_axi_araddr == OFF_INT_CTRL)  ? icWord
                      : (s_axi_araddr == OFF_IRQ_STAT)  ? {29'h0, evStat_r}
                      : (s_axi_araddr == OFF_IRQ_MASK)  ? {29'h0, evMask_r}
                      : (s_axi_araddr == OFF_CORE_STAT)
                        ? {29'h0, dsPending_r, tickPending_r, nmiPending_r}
                      : RESET_WORD;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rBusy_r <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= RESET_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !rBusy_r && !arTake;
            if (arTake) begin
                rBusy_r <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rOk ? rWord : RESET_WORD;
                s_axi_rresp <= rOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rBusy_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    a_nmi_set_pends: assert property (@(posedge clk_sys) disable iff (reset)
        (wrIc && wDat[IC_NMI_SET]) |=> nmiPending_r)
        else $error("NMI set write did not pend");
    a_nmi_entry_clr: assert property (@(posedge clk_sys) disable iff (reset)
        (nmiEntry && !(wrIc && wDat[IC_NMI_SET])) |=> !nmiPending_r)
        else $error("NMI pending survived handler entry");
    a_ds_clear_works: assert property (@(posedge clk_sys) disable iff (reset)
        (wrIc && wDat[IC_DS_CLR] && !wDat[IC_DS_SET]) |=> !dsPending_r)
        else $error("Deferred clear ignored");
    a_ds_set_pends: assert property (@(posedge clk_sys) disable iff (reset)
        (wrIc && wDat[IC_DS_SET]) |=> dsPending_r)
        else $error("Deferred set ignored");
    a_tick_set_clr: assert property (@(posedge clk_sys) disable iff (reset)
        (wrIc && wDat[IC_TICK_CLR] && !wDat[IC_TICK_SET]) |=> !tickPending_r)
        else $error("Tick clear ignored");
    a_tick_set_pends: assert property (@(posedge clk_sys) disable iff (reset)
        (wrIc && wDat[IC_TICK_SET]) |=> tickPending_r)
        else $error("Tick set ignored");
    a_trig_pends_irq: assert property (@(posedge clk_sys) disable iff (reset)
        wrTrig |=> irqPending_r[$past(wDat[TRIG_W-1:0])])
        else $error("Software trigger did not pend IRQ");
    a_unpriv_blocked: assert property (@(posedge clk_sys) disable iff (reset)
        (doWrite && !wPriv) |=> $stable(noIfthenFold_r) && s_axi_bresp == RESP_SLVERR)
        else $error("Unprivileged write took effect");
    a_aux_write_bits: assert property (@(posedge clk_sys) disable iff (reset)
        wrAux |=> noWriteBuffer_r == $past(wDat[AUX_NO_WBUF])
               && noMulticycleInt_r == $past(wDat[AUX_NO_MCYC]))
        else $error("Auxiliary bits not stored");
    a_pend_none_code: assert property (@(posedge clk_sys) disable iff (reset)
        !(nmiPending_r || dsPending_r || tickPending_r || anyIrq) |-> pendNum == EXC_NONE)
        else $error("Pending number wrong when idle");
endmodule
`default_nettype wire

/* File: rtl/sysctl_pkg.sv */
// Constants for the system control register block.
// Assumes an AXI4-Lite slave with 32-bit data and 12-bit byte addresses.
package sysctl_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFF_AUX_CTRL  = 12'h008;
    localparam logic [11:0] OFF_PROC_ID   = 12'hD00;
    localparam logic [11:0] OFF_INT_CTRL  = 12'hD04;
    localparam logic [11:0] OFF_SW_TRIG   = 12'hF00;
    localparam logic [11:0] OFF_IRQ_STAT  = 12'hF10;
    localparam logic [11:0] OFF_IRQ_MASK  = 12'hF14;
    localparam logic [11:0] OFF_CORE_STAT = 12'hF18;
    // ==========================================================
    // Field positions
    localparam int AUX_NO_MCYC    = 0;
    localparam int AUX_NO_WBUF    = 1;
    localparam int AUX_NO_FOLD    = 2;
    localparam int IC_NMI_SET     = 31;
    localparam int IC_DS_SET      = 28;
    localparam int IC_DS_CLR      = 27;
    localparam int IC_TICK_SET    = 26;
    localparam int IC_TICK_CLR    = 25;
    localparam int IC_ANY_PEND    = 22;
    localparam int IC_PEND_LSB    = 12;
    localparam int IC_RET_BASE    = 11;
    localparam int TRIG_W         = 6;
    localparam int NUM_IRQ        = 64;
    // ==========================================================
    // Identification (values arbitrary, neutral)
    localparam logic [7:0]  ID_IMPLEMENTER = 8'h5A;
    localparam logic [3:0]  ID_VARIANT     = 4'h1;
    localparam logic [3:0]  ID_CONSTANT    = 4'h3;
    localparam logic [11:0] ID_PART        = 12'h123;
    localparam logic [3:0]  ID_REVISION    = 4'h1;
    // ==========================================================
    // Exception numbers
    localparam logic [6:0] EXC_NONE = 7'h00;
    localparam logic [6:0] EXC_NMI  = 7'h02;
    localparam logic [6:0] EXC_DS   = 7'h0E;
    localparam logic [6:0] EXC_TICK = 7'h0F;
    localparam logic [6:0] EXC_IRQ0 = 7'h10;
    // ==========================================================
    // Event bits in status and mask registers
    localparam int EV_SW_TRIG = 0;
    localparam int EV_NMI    = 1;
    localparam int EV_DENIED = 2;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // ==========================================================
    // Bus FSM states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_RESP = 3'b010,
        BUS_HOLD = 3'b100
    } bus_state_t;
endpackage

/* File: testbench/tb_system_control_register_block.sv */
// Self-checking bench for the system control register block.
// Assumes the package constants and an AXI4-Lite slave answering in a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_system_control_register_block;
    import sysctl_pkg::*;
    // ==========================================================
    // Signals
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata  = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb  = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [6:0]  activeExc = '0;
    logic [5:0]  irqTakenNum = '0;
    logic        preemptedActive = 1'b0, nmiEntry = 1'b0, dsTaken = 1'b0;
    logic        tickTaken = 1'b0, irqTaken = 1'b0;
    logic        noIfthenFold_r, noWriteBuffer_r, noMulticycleInt_r;
    logic        nmiPending_r, dsPending_r, tickPending_r, irq_r;
    logic [63:0] irqPending_r;
    logic [31:0] d;
    logic [1:0]  r;
    int          bad_count = 0;
    int          n_tests   = 0;

    always #25 clk_sys = ~clk_sys;

    sys_control_regs DUT (
        .clk_sys(clk_sys), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .activeExc(activeExc), .preemptedActive(preemptedActive),
        .nmiEntry(nmiEntry), .dsTaken(dsTaken), .tickTaken(tickTaken), .irqTaken(irqTaken),
        .irqTakenNum(irqTakenNum), .noIfthenFold_r(noIfthenFold_r), .noWriteBuffer_r(noWriteBuffer_r),
        .noMulticycleInt_r(noMulticycleInt_r), .nmiPending_r(nmiPending_r), .dsPending_r(dsPending_r),
        .tickPending_r(tickPending_r), .irqPending_r(irqPending_r), .irq_r(irq_r)
    );

    // ==========================================================
    // Bus tasks: handshakes judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [2:0] p,
                      input logic [3:0] s, output logic [1:0] resp);
        logic awHs, wHs, bHs, got;
        int   n;
        got = 1'b0;
        n   = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a; s_axi_awprot <= p; s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v; s_axi_wstrb <= s; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!got && n < 200) begin
            @(negedge clk_sys);
            awHs = s_axi_awvalid & s_axi_awready;
            wHs  = s_axi_wvalid & s_axi_wready;
            bHs  = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (awHs) s_axi_awvalid <= 1'b0;
            if (wHs) s_axi_wvalid <= 1'b0;
            if (bHs) begin
                s_axi_bready <= 1'b0;
                got = 1'b1;
            end
            n++;
        end
        if (!got) bad_count++;
    endtask

    task automatic rd(input logic [11:0] a, input logic [2:0] p, output logic [31:0] v,
                      output logic [1:0] resp);
        logic arHs, got;
        int   n;
        got = 1'b0;
        n   = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a; s_axi_arprot <= p; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!got && n < 200) begin
            @(negedge clk_sys);
            arHs = s_axi_arvalid & s_axi_arready;
            got  = s_axi_rvalid;
            v    = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (arHs) s_axi_arvalid <= 1'b0;
            if (got) s_axi_rready <= 1'b0;
            n++;
        end
        if (!got) bad_count++;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Privileged full-word accesses, the normal case
    task automatic pw(input logic [11:0] a, input logic [31:0] v);
        wr(a, v, 3'b001, 4'hF, r);
    endtask

    task automatic pr(input logic [11:0] a);
        rd(a, 3'b001, d, r);
    endtask

    function automatic logic [31:0] ic(input logic nmi, ds, tick, input logic [6:0] pend,
                                       input logic any, ret, input logic [6:0] act);
        return {nmi, 2'b0, ds, 1'b0, tick, 3'b0, any, 3'b0, pend, ret, 4'b0, act};
    endfunction

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the tests need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        pr(OFF_AUX_CTRL); chk("aux reset", d, 0);
        pr(OFF_PROC_ID); chk("id", d, {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT, ID_PART, ID_REVISION});
        pw(OFF_PROC_ID, 32'hFFFF_FFFF);
        pr(OFF_PROC_ID); chk("id after write", d, {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT, ID_PART, ID_REVISION});
        pr(OFF_INT_CTRL); chk("ictl reset", d, ic(0, 0, 0, EXC_NONE, 0, 1, 0));
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            pw(OFF_AUX_CTRL, 32'h1 << i);
            pr(OFF_AUX_CTRL); chk("aux bit", d, 32'h1 << i);
            chk("aux pins", {noIfthenFold_r, noWriteBuffer_r, noMulticycleInt_r}, 64'h1 << i);
        end
        pw(OFF_AUX_CTRL, 32'hFFFF_FFFF);
        pr(OFF_AUX_CTRL); chk("aux reserved", d, 32'h7);
        $display("test aux done");
        wr(OFF_AUX_CTRL, 0, 3'b000, 4'hF, r); chk("unpriv wr resp", r, RESP_SLVERR);
        pr(OFF_AUX_CTRL); chk("aux after unpriv", d, 32'h7);
        rd(OFF_AUX_CTRL, 3'b000, d, r); chk("unpriv rd resp", r, RESP_SLVERR);
        chk("unpriv rd data", d, 0);
        wr(OFF_AUX_CTRL, 0, 3'b001, 4'h3, r); chk("part wr resp", r, RESP_SLVERR);
        pr(OFF_AUX_CTRL); chk("aux after part", d, 32'h7);
        pr(12'h010); chk("unmapped resp", r, RESP_SLVERR);
        pw(OFF_AUX_CTRL, 0);
        $display("test access done");
        pw(OFF_SW_TRIG, 32'h3); chk("irq3 pend", irqPending_r, 64'h8);
        pw(OFF_SW_TRIG, 32'h3F); chk("irq63 pend", irqPending_r, 64'h8000_0000_0000_0008);
        pr(OFF_INT_CTRL); chk("ictl irq3", d, ic(0, 0, 0, EXC_IRQ0 + 7'd3, 1, 1, 0));
        @(posedge clk_sys) begin irqTaken <= 1'b1; irqTakenNum <= 6'd3; end
        @(posedge clk_sys) irqTaken <= 1'b0;
        pr(OFF_INT_CTRL); chk("ictl irq63", d, ic(0, 0, 0, EXC_IRQ0 + 7'd63, 1, 1, 0));
        @(posedge clk_sys) begin irqTaken <= 1'b1; irqTakenNum <= 6'd63; end
        @(posedge clk_sys) irqTaken <= 1'b0;
        pr(OFF_INT_CTRL); chk("ictl none", d, ic(0, 0, 0, EXC_NONE, 0, 1, 0));
        $display("test trigger done");
        pw(OFF_INT_CTRL, 32'h8000_0000); chk("nmi pin", nmiPending_r, 1);
        pw(OFF_INT_CTRL, 32'h0);
        pr(OFF_INT_CTRL); chk("ictl nmi", d, ic(1, 0, 0, EXC_NMI, 0, 1, 0));
        pr(OFF_CORE_STAT); chk("core stat nmi", d, 32'h1);
        @(posedge clk_sys) nmiEntry <= 1'b1;
        @(posedge clk_sys) nmiEntry <= 1'b0;
        pr(OFF_INT_CTRL); chk("ictl nmi taken", d, ic(0, 0, 0, EXC_NONE, 0, 1, 0));
        $display("test nmi done");
        pw(OFF_SW_TRIG, 32'h5);
        pw(OFF_INT_CTRL, 32'h1400_0000);
        pr(OFF_INT_CTRL); chk("ictl tick", d, ic(0, 1, 1, EXC_TICK, 1, 1, 0));
        pw(OFF_INT_CTRL, 32'h0200_0000); chk("tick pin", tickPending_r, 0);
        pr(OFF_INT_CTRL); chk("ictl ds", d, ic(0, 1, 0, EXC_DS, 1, 1, 0));
        pw(OFF_INT_CTRL, 32'h0800_0000); chk("ds pin", dsPending_r, 0);
        pr(OFF_INT_CTRL); chk("ictl irq5", d, ic(0, 0, 0, EXC_IRQ0 + 7'd5, 1, 1, 0));
        pw(OFF_INT_CTRL, 32'h1400_0000);
        @(posedge clk_sys) begin dsTaken <= 1'b1; tickTaken <= 1'b1; irqTaken <= 1'b1; irqTakenNum <= 6'd5; end
        @(posedge clk_sys) begin dsTaken <= 1'b0; tickTaken <= 1'b0; irqTaken <= 1'b0; end
        pr(OFF_INT_CTRL); chk("ictl all taken", d, ic(0, 0, 0, EXC_NONE, 0, 1, 0));
        @(posedge clk_sys) begin activeExc <= 7'h15; preemptedActive <= 1'b1; end
        pr(OFF_INT_CTRL); chk("ictl active", d, ic(0, 0, 0, EXC_NONE, 0, 0, 7'h15));
        $display("test pending done");
        pw(OFF_IRQ_STAT, 32'h7);
        pw(OFF_IRQ_MASK, 32'h0);
        pw(OFF_SW_TRIG, 32'h1);
        pr(OFF_IRQ_STAT); chk("stat trig", d, 32'h1 << EV_SW_TRIG);
        repeat (3) @(negedge clk_sys);
        chk("irq masked", irq_r, 0);
        pw(OFF_IRQ_MASK, 32'h7);
        repeat (3) @(negedge clk_sys);
        chk("irq raised", irq_r, 1);
        pw(OFF_IRQ_STAT, 32'h1);
        repeat (3) @(negedge clk_sys);
        chk("irq cleared", irq_r, 0);
        pw(OFF_INT_CTRL, 32'h8000_0000);
        wr(OFF_AUX_CTRL, 32'h7, 3'b000, 4'hF, r);
        pr(OFF_IRQ_STAT); chk("stat denied", d, (32'h1 << EV_DENIED) | (32'h1 << EV_NMI));
        chk("irq denied", irq_r, 1);
        $display("test events done");
        // Mid-run reset must return event status, IRQ pending bits, irq_r and NMI pending to idle
        @(posedge clk_sys) reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        pr(OFF_IRQ_STAT); chk("stat after reset", d, 0);
        chk("pend after reset", irqPending_r, 0);
        chk("pins after reset", {irq_r, nmiPending_r}, 0);
        $display("test reset again done");
        end_sim();
    end
endmodule
`default_nettype wire
